// ===== rtl/injector_edge_timing_regs.vh
// Register map, field layout and timing constants of the injector edge timing block
`ifndef INJECTOR_EDGE_TIMING_REGS_VH
`define INJECTOR_EDGE_TIMING_REGS_VH

`define IET_ADDR_W 9
`define IET_CTRL 9'h000
`define IET_OPEN_OFFSET 9'h004
`define IET_DIESEL_DELAY 9'h008
`define IET_EXTRA_DELAY 9'h00C
`define IET_OFFSET_X 9'h010
`define IET_OFFSET_Y 9'h014
`define IET_TBL_COUNT 9'h018
`define IET_STATUS 9'h01C
`define IET_DURATION 9'h020
`define IET_TBL_SEL_BIT 8
`define IET_TBL_IDX_MSB 6
`define IET_TBL_IDX_LSB 2
`define IET_TBL_POINTS 32

`define IET_CTRL_GAS_BIT 0
`define IET_CTRL_DMODE_MSB 2
`define IET_CTRL_DMODE_LSB 1
`define IET_CTRL_RESET 3'h0

`define IET_DMODE_LEGACY 2'h0
`define IET_DMODE_ON 2'h1
`define IET_DMODE_DELAY 2'h2

`define IET_OFFSET_LIMIT 16'h01F4
`define IET_TIME_RESET 16'h0000
`define IET_TIME_MAX 16'hFFFF

`define IET_CLK_PERIOD_NS 20
`define IET_US_NS 1000
`define IET_US_CYCLES (`IET_US_NS / `IET_CLK_PERIOD_NS)

`define IET_PH_IDLE 3'h0
`define IET_PH_BOOST 3'h1
`define IET_PH_PICKUP 3'h2
`define IET_PH_HOLD 3'h3
`define IET_PH_OFF 3'h4

`endif

// ===== rtl/us_tick_gen.v
// Microsecond enable pulse derived from the system clock
`timescale 1ns/1ps
`default_nettype none
module us_tick_gen #(
  parameter integer DIV = 50
) (
  input wire ref_clk_i,
  input wire rst_i,
  output reg tick_o
);
  reg [7:0] cnt;

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt <= 8'h00;
      tick_o <= 1'b0;
    end else if (cnt == DIV[7:0] - 8'h01) begin
      cnt <= 8'h00;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + 8'h01;
      tick_o <= 1'b0;
    end
  end
endmodule // us_tick_gen
`default_nettype wire

// ===== rtl/injector_edge_timing.v
// Injection window and closing feature timing from injector threshold comparators
`timescale 1ns/1ps
`default_nettype none
`include "injector_edge_timing_regs.vh"
// What this block does
// R1: Injection window output is active low; low means simulated valve open.
// R2: Window falls on start-of-control threshold, optionally delayed by static opening offset.
// R3: Injector control tracked as booster, pickup, holding and switching-off phases.
// R4: Gasoline mode times start-voltage rise to last end-voltage undercut.
// R5: Software loads a table mapping control duration to closing delay.
// R6: Runtime x and y offsets are added to table input and output.
// R7: Diesel closing control raises the window when the feature occurs.
// R8: Legacy mode raises the window when current drops below second threshold.
// R9: Diesel feature after static delay; software disables mode before changing it.
// R10: Diesel feature generation starts on the first current threshold event.
// R11: Software keeps second current threshold below holding current ripple.
// R12: Up to 32 table points, linearly interpolated for the delay.
// R13: Each runtime offset saturates to plus or minus 500 microseconds.
// R14: Diesel mode 0 legacy, 1 closing control, 2 closing control with delay.
// R15: Durations and delays counted in microsecond ticks from the system clock.
// R16: Reset holds window high and clears pending measurement and feature delay.
module injector_edge_timing (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [`IET_ADDR_W-1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  input wire start_control_voltage_threshold_i,
  input wire end_control_voltage_threshold_i,
  input wire holding_pwm_voltage_threshold_i,
  input wire feature_start_current_threshold_i,
  input wire end_control_current_threshold_i,
  output reg injection_window_n_o,
  output reg closing_feature_o
);
  // Comparator pins: 0 start V, 1 end V, 2 holding PWM V, 3 feature I, 4 end I
  reg [4:0] sync1, sync2, sync3;
  wire [4:0] rise = sync2 & ~sync3;
  wire [4:0] fall = ~sync2 & sync3;
  wire us_tick;

  reg ack;
  reg [2:0] ctrl;
  reg [15:0] open_offset, diesel_delay, extra_delay, offset_x, offset_y;
  reg [5:0] tbl_count;
  reg [15:0] tbl_x [0:`IET_TBL_POINTS-1];
  reg [15:0] tbl_y [0:`IET_TBL_POINTS-1];

  reg [2:0] phase;
  reg [15:0] dur_cnt, dur_last;
  reg measuring, feat_armed;
  reg [15:0] open_cnt, fd_cnt;
  reg open_run, fd_run;

  localparam L_IDLE = 2'h0;
  localparam L_SEARCH = 2'h1;
  localparam L_DIV = 2'h2;
  localparam L_DONE = 2'h3;
  reg [1:0] lk_state;
  reg [4:0] lk_idx;
  reg [15:0] lk_x, lk_base, lk_den;
  reg [31:0] lk_q;
  reg [16:0] lk_rem;
  reg [5:0] lk_bit;
  reg lk_neg;

  wire gas_mode = ctrl[`IET_CTRL_GAS_BIT];
  wire [1:0] dmode = ctrl[`IET_CTRL_DMODE_MSB:`IET_CTRL_DMODE_LSB];
  wire diesel_cc = (dmode == `IET_DMODE_ON) || (dmode == `IET_DMODE_DELAY); // R14
  wire acc = (avs_read_i | avs_write_i) & ~ack;
  wire wr = avs_write_i & ack;
  wire [4:0] widx = avs_address_i[`IET_TBL_IDX_MSB:`IET_TBL_IDX_LSB];
  wire tbl_sel = avs_address_i[`IET_TBL_SEL_BIT];

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;

  function [15:0] merge16;
    input [15:0] old;
    input [15:0] nw;
    input [1:0] be;
    begin
      merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  // Signed offset clipped to the allowed window
  function [15:0] sat_off;
    input [15:0] v;
    begin
      if (!v[15] && v > `IET_OFFSET_LIMIT)
        sat_off = `IET_OFFSET_LIMIT;
      else if (v[15] && (~v + 16'h0001) > `IET_OFFSET_LIMIT)
        sat_off = ~`IET_OFFSET_LIMIT + 16'h0001;
      else
        sat_off = v;
    end
  endfunction

  // Unsigned time plus saturated signed offset, clamped to 0..max
  function [15:0] add_off;
    input [15:0] t;
    input [15:0] off;
    reg [16:0] s;
    reg [15:0] o;
    begin
      o = sat_off(off); // R13
      s = {1'b0, t} + {o[15], o};
      // Bit 16 set with a negative offset means the sum went below zero
      if (o[15])
        add_off = s[16] ? `IET_TIME_RESET : s[15:0];
      else
        add_off = s[16] ? `IET_TIME_MAX : s[15:0];
    end
  endfunction

  us_tick_gen #(.DIV(`IET_US_CYCLES)) u_tick (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .tick_o(us_tick)
  );

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      sync3 <= 5'h00;
    end else begin
      sync1 <= {end_control_current_threshold_i, feature_start_current_threshold_i,
                holding_pwm_voltage_threshold_i, end_control_voltage_threshold_i,
                start_control_voltage_threshold_i};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Register bus: answer one cycle after the request appears
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      avs_readdata_o <= 32'h00000000;
      ctrl <= `IET_CTRL_RESET;
      open_offset <= `IET_TIME_RESET;
      diesel_delay <= `IET_TIME_RESET;
      extra_delay <= `IET_TIME_RESET;
      offset_x <= `IET_TIME_RESET;
      offset_y <= `IET_TIME_RESET;
      tbl_count <= 6'h00;
    end else begin
      ack <= acc;
      if (acc && avs_read_i) begin
        avs_readdata_o <= 32'h00000000;
        if (tbl_sel)
          avs_readdata_o <= {tbl_y[widx], tbl_x[widx]};
        else
          case (avs_address_i)
            `IET_CTRL: avs_readdata_o <= {29'h0, ctrl};
            `IET_OPEN_OFFSET: avs_readdata_o <= {16'h0, open_offset};
            `IET_DIESEL_DELAY: avs_readdata_o <= {16'h0, diesel_delay};
            `IET_EXTRA_DELAY: avs_readdata_o <= {16'h0, extra_delay};
            `IET_OFFSET_X: avs_readdata_o <= {16'h0, offset_x};
            `IET_OFFSET_Y: avs_readdata_o <= {16'h0, offset_y};
            `IET_TBL_COUNT: avs_readdata_o <= {26'h0, tbl_count};
            `IET_STATUS: avs_readdata_o <= {24'h0, lk_state != L_IDLE, fd_run, measuring,
                                            injection_window_n_o, 1'b0, phase};
            `IET_DURATION: avs_readdata_o <= {16'h0, dur_last};
            default: avs_readdata_o <= 32'h00000000;
          endcase
      end
      if (wr && !tbl_sel) begin
        case (avs_address_i)
          `IET_CTRL: if (avs_byteenable_i[0]) ctrl <= avs_writedata_i[2:0];
          `IET_OPEN_OFFSET: open_offset <= merge16(open_offset, avs_writedata_i[15:0],
                                                   avs_byteenable_i[1:0]);
          // Static delay only changes while closing control is off
          `IET_DIESEL_DELAY: if (!diesel_cc) diesel_delay <= merge16(diesel_delay, // R9
                               avs_writedata_i[15:0], avs_byteenable_i[1:0]);
          `IET_EXTRA_DELAY: if (!diesel_cc) extra_delay <= merge16(extra_delay,
                              avs_writedata_i[15:0], avs_byteenable_i[1:0]);
          `IET_OFFSET_X: offset_x <= merge16(offset_x, avs_writedata_i[15:0],
                                             avs_byteenable_i[1:0]);
          `IET_OFFSET_Y: offset_y <= merge16(offset_y, avs_writedata_i[15:0],
                                             avs_byteenable_i[1:0]);
          `IET_TBL_COUNT: if (avs_byteenable_i[0])
            tbl_count <= (avs_writedata_i[5:0] > `IET_TBL_POINTS) ? 6'h20 : avs_writedata_i[5:0];
          default: ;
        endcase
      end
    end
  end

  // Table memory has no reset; software loads it during configuration
  always @(posedge ref_clk_i) begin
    if (wr && tbl_sel) begin
      tbl_x[widx] <= merge16(tbl_x[widx], avs_writedata_i[15:0], avs_byteenable_i[1:0]); // R12
      tbl_y[widx] <= merge16(tbl_y[widx], avs_writedata_i[31:16], avs_byteenable_i[3:2]);
    end
  end

  wire [15:0] ys = tbl_y[lk_idx];
  wire [15:0] ye = tbl_y[lk_idx + 5'h01];
  wire [15:0] xs = tbl_x[lk_idx];
  wire [15:0] xe = tbl_x[lk_idx + 5'h01];
  wire [16:0] rem_sh = {lk_rem[15:0], lk_q[31]};
  wire gas_start = gas_mode && feat_armed && fall[3];
  wire dsl_start = !gas_mode && diesel_cc && feat_armed && fall[3];
  wire end_event = gas_mode ? fall[1] : fall[4];
  wire feature_now = fd_run && (fd_cnt == `IET_TIME_RESET);
  wire lk_done = (lk_state == L_DONE);
  wire [15:0] lk_y = lk_neg ? lk_base - lk_q[15:0] : lk_base + lk_q[15:0];

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      phase <= `IET_PH_IDLE;
      dur_cnt <= `IET_TIME_RESET;
      dur_last <= `IET_TIME_RESET;
      measuring <= 1'b0; // R16
      feat_armed <= 1'b0;
      open_cnt <= `IET_TIME_RESET;
      open_run <= 1'b0;
      fd_cnt <= `IET_TIME_RESET;
      fd_run <= 1'b0; // R16
      lk_state <= L_IDLE;
      lk_idx <= 5'h00;
      lk_x <= `IET_TIME_RESET;
      lk_base <= `IET_TIME_RESET;
      lk_den <= `IET_TIME_RESET;
      lk_q <= 32'h00000000;
      lk_rem <= 17'h00000;
      lk_bit <= 6'h00;
      lk_neg <= 1'b0;
      injection_window_n_o <= 1'b1; // R16
      closing_feature_o <= 1'b0;
    end else begin
      closing_feature_o <= feature_now;
      if (rise[0]) begin
        phase <= `IET_PH_BOOST; // R3
        measuring <= 1'b1;
        dur_cnt <= `IET_TIME_RESET;
        feat_armed <= 1'b1;
        fd_run <= 1'b0;
        if (open_offset == `IET_TIME_RESET)
          injection_window_n_o <= 1'b0; // R1 R2
        else begin
          open_run <= 1'b1;
          open_cnt <= open_offset; // R2
        end
      end else begin
        case (phase)
          `IET_PH_BOOST: if (end_event) phase <= `IET_PH_OFF;
            else if (rise[3] || fall[1]) phase <= `IET_PH_PICKUP; // R3
          `IET_PH_PICKUP: if (end_event) phase <= `IET_PH_OFF;
            else if (rise[2]) phase <= `IET_PH_HOLD; // R3
          `IET_PH_HOLD: if (end_event) phase <= `IET_PH_OFF; // R3
          `IET_PH_OFF: if (injection_window_n_o && !fd_run && lk_state == L_IDLE)
            phase <= `IET_PH_IDLE;
          default: phase <= `IET_PH_IDLE;
        endcase
        if (measuring && us_tick && dur_cnt != `IET_TIME_MAX)
          dur_cnt <= dur_cnt + 16'h0001; // R15
        if (measuring && fall[1])
          dur_last <= dur_cnt; // R4
        if (open_run && us_tick) begin
          if (open_cnt == 16'h0001) begin
            open_run <= 1'b0;
            injection_window_n_o <= 1'b0; // R2
          end
          open_cnt <= open_cnt - 16'h0001;
        end
      end
      // Gasoline: duration shifted by x offset goes into the curve search
      if (gas_start) begin
        feat_armed <= 1'b0;
        measuring <= 1'b0;
        lk_x <= add_off(dur_last, offset_x); // R6
        lk_idx <= 5'h00;
        lk_state <= L_SEARCH;
      end
      if (dsl_start) begin
        feat_armed <= 1'b0; // R10
        measuring <= 1'b0;
        fd_run <= 1'b1;
        fd_cnt <= (dmode == `IET_DMODE_DELAY) ? diesel_delay + extra_delay : diesel_delay; // R9
      end
      case (lk_state)
        L_IDLE: ;
        L_SEARCH: begin
          lk_base <= ys;
          lk_neg <= ye < ys;
          lk_q <= 32'h00000000;
          if (tbl_count < 6'h02 || lk_x <= xs)
            lk_state <= L_DONE; // Clamp below first point
          else if ({1'b0, lk_idx} + 6'h02 >= tbl_count && lk_x >= xe) begin
            lk_base <= ye;
            lk_state <= L_DONE; // Clamp past last point
          end else if (lk_x >= xe)
            lk_idx <= lk_idx + 5'h01;
          else begin
            lk_q <= (lk_x - xs) * ((ye < ys) ? ys - ye : ye - ys); // R12
            lk_den <= xe - xs;
            lk_rem <= 17'h00000;
            lk_bit <= 6'h20;
            lk_state <= L_DIV;
          end
        end
        L_DIV: begin
          // Restoring division, one quotient bit per cycle
          if (rem_sh >= {1'b0, lk_den}) begin
            lk_rem <= rem_sh - {1'b0, lk_den};
            lk_q <= {lk_q[30:0], 1'b1};
          end else begin
            lk_rem <= rem_sh;
            lk_q <= {lk_q[30:0], 1'b0};
          end
          lk_bit <= lk_bit - 6'h01;
          if (lk_bit == 6'h01)
            lk_state <= L_DONE;
        end
        L_DONE: begin
          lk_state <= L_IDLE;
          fd_run <= 1'b1;
          fd_cnt <= add_off(lk_y, offset_y); // R6
        end
        default: lk_state <= L_IDLE;
      endcase
      if (fd_run && !feature_now && us_tick && !lk_done && !dsl_start)
        fd_cnt <= fd_cnt - 16'h0001; // R15
      if (feature_now && !lk_done && !dsl_start && !rise[0]) begin
        fd_run <= 1'b0;
        if (gas_mode || diesel_cc)
          injection_window_n_o <= 1'b1; // R7
      end
      if (!gas_mode && !diesel_cc && fall[4] && !rise[0]) begin
        injection_window_n_o <= 1'b1; // R8
        open_run <= 1'b0;
        measuring <= 1'b0;
      end
    end
  end
endmodule // injector_edge_timing
`default_nettype wire

// ===== sim/injector_edge_timing_properties.sv
// Port-level assertions for the injector edge timing block
`timescale 1ns/1ps
`default_nettype none
module injector_edge_timing_props (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic start_control_voltage_threshold_i,
  input wire logic feature_start_current_threshold_i,
  input wire logic end_control_current_threshold_i,
  input wire logic injection_window_n_o,
  input wire logic closing_feature_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  property p_rst_idle;
    rst_i |=> injection_window_n_o && !closing_feature_o && avs_readdata_o == 32'h0;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs active after reset");
  property p_first_wait;
    disable iff (rst_i) $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o;
  endproperty
  a_first_wait: assert property (p_first_wait) else $error("request answered at once");
  property p_one_wait;
    disable iff (rst_i) (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("more than one wait cycle");
  property p_idle_wait;
    disable iff (rst_i) !(avs_read_i || avs_write_i) |-> !avs_waitrequest_o;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("wait raised while idle");
  property p_open_cause;
    disable iff (rst_i) $fell(injection_window_n_o) |-> $past(start_control_voltage_threshold_i, 3);
  endproperty
  a_open_cause: assert property (p_open_cause) else $error("window fell without start");
  property p_close_cause;
    disable iff (rst_i) $rose(injection_window_n_o) |->
      closing_feature_o || !$past(end_control_current_threshold_i, 3);
  endproperty
  a_close_cause: assert property (p_close_cause) else $error("window rose without cause");
  property p_pulse;
    disable iff (rst_i) closing_feature_o |=> !closing_feature_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("feature longer than one cycle");
  property p_feat_cause;
    disable iff (rst_i) closing_feature_o |-> !$past(feature_start_current_threshold_i, 3);
  endproperty
  a_feat_cause: assert property (p_feat_cause) else $error("feature before current fell");
endmodule // injector_edge_timing_props
bind injector_edge_timing injector_edge_timing_props i_props (.ref_clk_i, .rst_i, .avs_read_i,
  .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .start_control_voltage_threshold_i,
  .feature_start_current_threshold_i, .end_control_current_threshold_i,
  .injection_window_n_o, .closing_feature_o);
`default_nettype wire

// ===== sim/ecu_driver_model.sv
// Behavioural injector driver stage producing one shot of comparator events
`timescale 1ns/1ps
`default_nettype none
module ecu_driver_model (
  input wire logic ref_clk_i,
  input wire logic fire_i,
  input wire logic [15:0] len_i,
  output logic start_v_o,
  output logic end_v_o,
  output logic pwm_v_o,
  output logic feat_cur_o,
  output logic end_cur_o,
  output logic done_o
);
  logic [15:0] t = 16'hFFFF;
  logic pwm;
  assign pwm = (t > 16'h0064) && (t < len_i) && t[3];
  always @(posedge ref_clk_i) begin
    if (fire_i) t <= 16'h0000;
    else if (t != 16'hFFFF) t <= t + 16'h0001;
  end
  // Holding chops dip the end voltage, so only the final undercut ends control
  always @(posedge ref_clk_i) begin
    start_v_o <= (t < len_i);
    end_v_o <= (t < len_i) && !pwm;
    pwm_v_o <= pwm;
    feat_cur_o <= (t < len_i + 16'h0014);
    end_cur_o <= (t < len_i + 16'h003C);
    done_o <= (t > len_i + 16'h00C8);
  end
endmodule // ecu_driver_model
`default_nettype wire

// ===== sim/tb_injector_edge_timing.sv
// Self-checking bench for the injector edge timing block
`timescale 1ns/1ps
`default_nettype none
`include "injector_edge_timing_regs.vh"
module tb_injector_edge_timing;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [8:0] adr = 9'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic fire = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [15:0] len = 16'h03E8;
  logic [31:0] rdat;
  logic [31:0] q;
  logic wreq, sv, ev, pv, fc, ec, win_n, feat, done;
  int cyc, t_s, t_fc, t_ec, t_wf, t_wr, t_f, fail_count, check_count;
  always #10 ref_clk_i = ~ref_clk_i;
  injector_edge_timing i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .start_control_voltage_threshold_i(sv),
    .end_control_voltage_threshold_i(ev), .holding_pwm_voltage_threshold_i(pv),
    .feature_start_current_threshold_i(fc), .end_control_current_threshold_i(ec),
    .injection_window_n_o(win_n), .closing_feature_o(feat));
  ecu_driver_model i_ecu (.ref_clk_i(ref_clk_i), .fire_i(fire), .len_i(len), .start_v_o(sv),
    .end_v_o(ev), .pwm_v_o(pv), .feat_cur_o(fc), .end_cur_o(ec), .done_o(done));
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if ($rose(sv)) t_s <= cyc;
    if ($fell(fc)) t_fc <= cyc;
    if ($fell(ec)) t_ec <= cyc;
    if ($fell(win_n)) t_wf <= cyc;
    if ($rose(win_n)) t_wr <= cyc;
    if (feat === 1'b1) t_f <= cyc;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic near(input int v, input int lo, input int hi);
    check({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask
  // Values read at the edge are the pre-edge ones, which is what the slave presented
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    @(posedge ref_clk_i);
    while (wreq !== 1'b0 && n < 200) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 200) fail_count++;
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic shot(input logic [15:0] l);
    int n;
    n = 0;
    len <= l;
    fire <= 1'b1;
    @(posedge ref_clk_i);
    fire <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    while (!(done === 1'b1 && win_n === 1'b1) && n < 40000) begin
      @(posedge ref_clk_i);
      n++;
    end
    @(posedge ref_clk_i);
  endtask
  task automatic t_regs;
    bus(0, `IET_CTRL, 0);
    check(q, 32'h0);
    bus(1, 9'h040, 32'h00000055);
    bus(0, 9'h040, 0);
    check(q, 32'h0);
    $display("registers done");
  endtask
  task automatic t_legacy(input logic [31:0] off, input int lo, input int hi);
    bus(1, `IET_CTRL, 32'h0);
    bus(1, `IET_OPEN_OFFSET, off);
    shot(16'h03E8);
    near(t_wf - t_s, lo, hi);
    near(t_wr - t_ec, 2, 6);
    bus(0, `IET_STATUS, 0);
    check(q, 32'h10);
    $display("legacy done");
  endtask
  task automatic t_diesel(input logic [31:0] mode, input int lo, input int hi);
    bus(1, `IET_CTRL, 32'h0);
    bus(1, `IET_DIESEL_DELAY, 32'h5);
    bus(1, `IET_EXTRA_DELAY, 32'h3);
    bus(1, `IET_CTRL, mode << 1);
    bus(1, `IET_DIESEL_DELAY, 32'h9);
    bus(0, `IET_DIESEL_DELAY, 0);
    check(q, 32'h5);
    shot(16'h03E8);
    near(t_f - t_fc, lo, hi);
    check(t_wr, t_f);
    bus(1, `IET_CTRL, 32'h0);
    $display("diesel done");
  endtask
  task automatic t_gas(input logic [31:0] ox, oy, input int lo, hi);
    bus(1, `IET_OPEN_OFFSET, 32'h0);
    bus(1, 9'h100, 32'h0);
    bus(1, 9'h104, 32'h00C800C8);
    bus(1, `IET_TBL_COUNT, 32'h2);
    bus(1, `IET_OFFSET_X, ox);
    bus(1, `IET_OFFSET_Y, oy);
    bus(1, `IET_CTRL, 32'h1);
    shot(16'h1388);
    bus(0, `IET_DURATION, 0);
    near(q, 99, 101);
    near(t_f - t_fc, lo, hi);
    check(t_wr, t_f);
    $display("gasoline done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    check(win_n, 1);
    t_regs;
    t_legacy(0, 2, 8);
    t_legacy(2, 50, 110);
    t_diesel(`IET_DMODE_ON, 200, 320);
    t_diesel(`IET_DMODE_DELAY, 350, 470);
    t_gas(32'h0014, 32'h0258, 30900, 31250);
    // Negative x offset moves the lookup point down the curve
    t_gas(32'hFFEC, 32'h0064, 8950, 9100);
    conclude;
  end
  initial begin
    repeat (90000) @(posedge ref_clk_i);
    fail_count++;
    conclude;
  end
endmodule // tb_injector_edge_timing
`default_nettype wire
